// ### logic/scr_core.sv
// Purpose: Serially loaded command register with its control outputs.
// Assumes: The controller stops the shift clock before raising the strobe.
// Notes: The active register and history logic run on pclk.
//
// How it works
// R1: Every low and high gain chain has a 16-bit discriminator history.
// R2: History shifts at 4 MHz, and for 0.5 us after gate close.
// R3: After stopping, history holds unchanged until the gate drops; reading it does not release it.
// R4: Each chain's pulser has its own enable bit.
// R5: Enabled pulser follows stimulus gate: high level when high, else low.
// R6: Capacitance select of zero decouples the pulser from its preamp.
// R7: Four-bit monitor select routes one preamp only when enabled.
// R8: Probe mux is command driven; one source is the external probe.
// R9: Strobe rising edge copies the whole shadow into the command register.
// R10: Each shift clock rising edge shifts in one serial data bit.
// R11: Data out feeds next chip; clock out feeds the previous chip.
// R12: One common strobe goes to every chip of the chain.
// R13: Clear input low forces every command bit to zero asynchronously.
// R14: All-zero command leaves every chain powered off.
// R15: Without clear, command contents are arbitrary until load and strobe; here presetn also clears them to zero.
// R16: 846 bits per chip, first shifted is a rundown select.
// R17: 96 bits select rundown signals into three gated OR outputs.
// R18: Data out is the shadow's last stage; clock out copies clock in.
// R19: Shifting never disturbs the active command register.
`default_nettype none
module scr_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [scr_pkg::ADDR_W-1:0] paddr,
	input wire logic [scr_pkg::DATA_W-1:0] pwdata,
	output logic [scr_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmd_clk_in,
	input wire logic cmd_data_in,
	input wire logic cmd_strobe,
	input wire logic cmd_clear_n,
	output logic cmd_clk_out,
	output logic cmd_data_out,
	input wire logic [scr_pkg::CHAINS-1:0] disc_hg,
	input wire logic [scr_pkg::CHAINS-1:0] disc_lg,
	input wire logic gate_close,
	input wire logic stim_gate,
	output logic [scr_pkg::CHAINS-1:0] stim_connect_high,
	output logic [scr_pkg::CHAINS-1:0][scr_pkg::CAP_W-1:0] stim_cap_select,
	output logic [scr_pkg::CHAINS-1:0] stim_decouple,
	output logic [scr_pkg::CHAINS-1:0] chain_power_on,
	output logic [scr_pkg::CHAINS-1:0] monitor_route,
	output logic [scr_pkg::PROBE_SEL_W-1:0] probe_select,
	output logic probe_enable,
	output logic probe_ext_route,
	input wire logic [scr_pkg::GOR_WIDTH-1:0] rundown_in,
	output logic [scr_pkg::GOR_GROUPS-1:0] rundown_group_or
);
	import scr_pkg::*;

	// Every pclk flop lives in this one struct so that the clear pin and
	// the bus reset empty all of it at once. Keeping one reset domain costs
	// a little flexibility but leaves no half-cleared state behind.
	typedef struct packed {
		logic [CMD_BITS-1:0] cmd;
		logic [HIST_CHAINS-1:0] disc_s1;
		logic [HIST_CHAINS-1:0] disc_s2;
		logic [GOR_WIDTH-1:0] rdn_s1;
		logic [GOR_WIDTH-1:0] rdn_s2;
		logic [2:0] strobe_sync;
		logic [1:0] gate_sync;
		logic [1:0] stim_sync;
		logic [HIST_CHAINS-1:0][HIST_LEN-1:0] hist;
		logic [ACC_W-1:0] acc;
		logic [TAIL_W-1:0] tail;
		logic frozen;
		logic hist_hold;
		logic [SEL_W-1:0] hist_sel;
		logic [SEL_W-1:0] word_sel;
		logic [DATA_W-1:0] rdata;
		logic slverr;
		logic [CHAINS-1:0] stim_high;
		logic [CHAINS-1:0] mon_route;
		logic probe_ext;
		logic [GOR_GROUPS-1:0] gor;
		logic [COUNT_W-1:0] strobe_count;
	} scr_core_state_type;

	scr_core_state_type r_ff;
	scr_core_state_type nxt_r;
	logic [CMD_BITS-1:0] shadow;
	logic core_rst_n;
	logic strobe_rise;
	logic hist_tick;
	logic [ACC_W-1:0] acc_sum;
	logic [CMD_WORDS*32-1:0] cmd_padded;

	// The test fields run from the last chain to the first along the chain,
	// so both helpers mirror the chain index before picking a field.
	function automatic logic test_enable(input logic [CMD_BITS-1:0] c,
		input int i);
		test_enable = c[TEST_LSB + TEST_STRIDE * (CHAINS - 1 - i)
			+ TEST_ENABLE];
	endfunction

	function automatic logic [CAP_W-1:0] test_cap(
		input logic [CMD_BITS-1:0] c, input int i);
		test_cap = c[TEST_LSB + TEST_STRIDE * (CHAINS - 1 - i)
			+ TEST_CAP_LSB +: CAP_W];
	endfunction

	function automatic logic reg_known(input logic [ADDR_W-1:0] a);
		reg_known = (a == REG_STATUS) || (a == REG_CTRL)
			|| (a == REG_HIST_SEL) || (a == REG_HIST_DATA)
			|| (a == REG_WORD_SEL) || (a == REG_CMD_WORD);
	endfunction

	scr_shadow #(
		.WIDTH(CMD_BITS)
	) u_shadow (
		.shift_clk(cmd_clk_in),
		.presetn(presetn),
		.data_in(cmd_data_in),
		.shadow(shadow),
		.data_out(cmd_data_out)
	);

	// The shift clock passes straight through toward the upstream chip.
	assign cmd_clk_out = cmd_clk_in; // R11 R18

	// The clear pin acts as an asynchronous reset so that it works with
	// pclk stopped. Its release is not synchronised; it must be released
	// while the register is idle.
	assign core_rst_n = presetn & cmd_clear_n; // R13

	assign strobe_rise = r_ff.strobe_sync[1] & ~r_ff.strobe_sync[2];
	assign acc_sum = r_ff.acc + ACC_W'(HIST_MHZ);
	assign hist_tick = acc_sum >= ACC_W'(CLK_MHZ);
	assign cmd_padded = {{(CMD_WORDS * 32 - CMD_BITS){1'b0}}, r_ff.cmd};

	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.disc_s1 = {disc_lg, disc_hg};
		nxt_r.disc_s2 = r_ff.disc_s1;
		nxt_r.rdn_s1 = rundown_in;
		nxt_r.rdn_s2 = r_ff.rdn_s1;
		nxt_r.strobe_sync = {r_ff.strobe_sync[1:0], cmd_strobe};
		nxt_r.gate_sync = {r_ff.gate_sync[0], gate_close};
		nxt_r.stim_sync = {r_ff.stim_sync[0], stim_gate};

		// The shadow is quiet while the strobe is high, so the two-stage
		// strobe synchroniser also gives the shadow time to settle before
		// it is sampled in this domain.
		if (strobe_rise)
		begin
			nxt_r.cmd = shadow; // R9 R19
			nxt_r.strobe_count = r_ff.strobe_count + COUNT_W'(1);
		end

		// Phase accumulator gives an exact 4 MHz average tick from 10 MHz.
		if (hist_tick)
			nxt_r.acc = acc_sum - ACC_W'(CLK_MHZ);
		else
			nxt_r.acc = acc_sum;

		// The tail is counted from the synchronised gate, so the history
		// runs a little longer than the nominal tail after the pin rises.
		// Dropping the gate thaws the history for the next event, which is
		// why software must read it out before the gate reopens.
		if (!r_ff.gate_sync[1])
		begin
			nxt_r.frozen = 1'b0;
			nxt_r.tail = '0;
		end
		else if (!r_ff.frozen)
		begin
			if (r_ff.tail == TAIL_W'(HIST_TAIL_CYC - 1))
				nxt_r.frozen = 1'b1; // R2
			else
				nxt_r.tail = r_ff.tail + TAIL_W'(1);
		end

		if (hist_tick && !r_ff.frozen && !r_ff.hist_hold) // R3
		begin
			for (int c = 0; c < HIST_CHAINS; c++)
				nxt_r.hist[c] = {r_ff.hist[c][HIST_LEN-2:0],
					r_ff.disc_s2[c]}; // R1 R2
		end

		// A disabled pulser always sits on the low level, whatever the
		// stimulus gate does.
		for (int i = 0; i < CHAINS; i++)
			nxt_r.stim_high[i] = test_enable(r_ff.cmd, i)
				& r_ff.stim_sync[1]; // R4 R5

		// The shift gives a one-hot route, so two preamps can never share
		// the monitor pad.
		if (r_ff.cmd[MON_EN_BIT])
			nxt_r.mon_route = CHAINS'(1) << r_ff.cmd[MON_SEL_LSB +: MON_SEL_W];
		else
			nxt_r.mon_route = '0; // R7

		nxt_r.probe_ext = r_ff.cmd[PROBE_EN_BIT]
			&& (r_ff.cmd[PROBE_SEL_LSB +: PROBE_SEL_W] == PROBE_SRC_EXT); // R8

		// Group zero sits highest in the chain, so it is shifted in last.
		for (int g = 0; g < GOR_GROUPS; g++)
			nxt_r.gor[g] = |(r_ff.rdn_s2 & r_ff.cmd[GOR_LSB
				+ (GOR_GROUPS - 1 - g) * GOR_WIDTH +: GOR_WIDTH]); // R17 R16

		// Read data is prepared in the setup phase for a zero-wait access.
		if (psel && !penable)
		begin
			nxt_r.slverr = !reg_known(paddr);
			nxt_r.rdata = '0;
			unique case (paddr)
				REG_STATUS:
				begin
					nxt_r.rdata[ST_FROZEN] = r_ff.frozen;
					nxt_r.rdata[ST_GATE] = r_ff.gate_sync[1];
					nxt_r.rdata[ST_STIM] = r_ff.stim_sync[1];
					nxt_r.rdata[ST_COUNT_LSB +: COUNT_W] = r_ff.strobe_count;
				end
				REG_CTRL:
					nxt_r.rdata[CTRL_HOLD_BIT] = r_ff.hist_hold;
				REG_HIST_SEL:
					nxt_r.rdata[SEL_W-1:0] = r_ff.hist_sel;
				REG_HIST_DATA:
					nxt_r.rdata[HIST_LEN-1:0] = r_ff.hist[r_ff.hist_sel];
				REG_WORD_SEL:
					nxt_r.rdata[SEL_W-1:0] = r_ff.word_sel;
				REG_CMD_WORD:
					if (r_ff.word_sel < SEL_W'(CMD_WORDS))
						nxt_r.rdata = cmd_padded[r_ff.word_sel * 32 +: 32];
				default:
					nxt_r.rdata = '0;
			endcase
		end

		// Writes land at the access edge; an unmapped address matches none
		// of the writable registers and so changes nothing.
		if (psel && penable && pwrite)
		begin
			if (paddr == REG_CTRL)
				nxt_r.hist_hold = pwdata[CTRL_HOLD_BIT];
			if (paddr == REG_HIST_SEL)
				nxt_r.hist_sel = pwdata[SEL_W-1:0];
			if (paddr == REG_WORD_SEL)
				nxt_r.word_sel = pwdata[SEL_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge core_rst_n)
	begin
		if (!core_rst_n)
			r_ff <= '0; // R13 R14
		else
			r_ff <= nxt_r;
	end

	// Per-chain fields come straight from the command flops, so they
	// change only when the command register itself changes.
	genvar gi;
	generate
		for (gi = 0; gi < CHAINS; gi++)
		begin : g_chain
			assign stim_cap_select[gi] = test_cap(r_ff.cmd, gi); // R6
			assign stim_decouple[gi] = test_cap(r_ff.cmd, gi) == '0; // R6
			assign chain_power_on[gi] = r_ff.cmd[PCTL_LSB
				+ PCTL_STRIDE * gi + PCTL_POWER]; // R14
		end
	endgenerate

	assign stim_connect_high = r_ff.stim_high;
	assign monitor_route = r_ff.mon_route;
	assign probe_select = r_ff.cmd[PROBE_SEL_LSB +: PROBE_SEL_W];
	assign probe_enable = r_ff.cmd[PROBE_EN_BIT];
	assign probe_ext_route = r_ff.probe_ext;
	assign rundown_group_or = r_ff.gor;
	assign prdata = r_ff.rdata;
	assign pslverr = r_ff.slverr;
	// Read data is ready by the access phase, so no wait state is needed.
	assign pready = 1'b1;
endmodule
`default_nettype wire

// ### logic/scr_shadow.sv
// Purpose: Shadow shift register clocked by the serial shift clock.
// Assumes: Serial data is launched by the upstream chip on the same clock.
// Notes: Contents are cleared to zero by presetn and change only as bits are shifted in.
`default_nettype none
module scr_shadow #(
	parameter int WIDTH = scr_pkg::CMD_BITS
) (
	input wire logic shift_clk,
	input wire logic presetn,
	input wire logic data_in,
	output logic [WIDTH-1:0] shadow,
	output logic data_out
);
	import scr_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] bits;
	} scr_shadow_state_type;

	scr_shadow_state_type r_ff;
	scr_shadow_state_type nxt_r;

	always_comb
	begin
		nxt_r = r_ff;
		// New bits enter at the top; the oldest bit leaves at bit zero.
		nxt_r.bits = {data_in, r_ff.bits[WIDTH-1:1]}; // R10
	end

	always_ff @(posedge shift_clk or negedge presetn)
	begin
		if (!presetn)
			r_ff <= '0;
		else
			r_ff <= nxt_r;
	end

	assign shadow = r_ff.bits;
	assign data_out = r_ff.bits[0]; // R18
endmodule
`default_nettype wire

// ### shared/scr_pkg.sv
// Purpose: Constants shared by the serial command register design.
// Assumes: Command bit positions count from the end of the shadow chain
// that leaves the chip; bit 845 is the last bit shifted in.
// Notes: Register offsets are byte addresses on the APB port.
`default_nettype none
package scr_pkg;
	localparam int CMD_BITS = 846;
	localparam int CMD_WORDS = (CMD_BITS + 31) / 32;
	localparam int CHAINS = 16;
	localparam int HIST_CHAINS = 2 * CHAINS;
	localparam int HIST_LEN = 16;
	localparam int GOR_GROUPS = 3;
	localparam int GOR_WIDTH = 32;
	localparam int CAP_W = 4;
	localparam int MON_SEL_W = 4;
	localparam int PROBE_SEL_W = 8;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int SEL_W = 5;

	// Command field positions.
	localparam int GOR_LSB = 0;
	localparam int PCTL_LSB = 96;
	localparam int PCTL_STRIDE = 4;
	localparam int PCTL_POWER = 0;
	localparam int TEST_LSB = 688;
	localparam int TEST_STRIDE = 9;
	localparam int TEST_ENABLE = 8;
	localparam int TEST_CAP_LSB = 4;
	localparam int MON_EN_BIT = 832;
	localparam int MON_SEL_LSB = 833;
	localparam int PROBE_EN_BIT = 837;
	localparam int PROBE_SEL_LSB = 838;
	localparam logic [PROBE_SEL_W-1:0] PROBE_SRC_EXT = 8'h01;

	// APB register map.
	localparam logic [ADDR_W-1:0] REG_STATUS = 12'h000;
	localparam logic [ADDR_W-1:0] REG_CTRL = 12'h004;
	localparam logic [ADDR_W-1:0] REG_HIST_SEL = 12'h008;
	localparam logic [ADDR_W-1:0] REG_HIST_DATA = 12'h00c;
	localparam logic [ADDR_W-1:0] REG_WORD_SEL = 12'h010;
	localparam logic [ADDR_W-1:0] REG_CMD_WORD = 12'h014;
	localparam int CTRL_HOLD_BIT = 0;
	localparam int ST_FROZEN = 0;
	localparam int ST_GATE = 1;
	localparam int ST_STIM = 2;
	localparam int ST_COUNT_LSB = 16;
	localparam int COUNT_W = 16;

	// Timing.
	localparam int CLK_MHZ = 10;
	localparam int HIST_MHZ = 4;
	localparam int ACC_W = 5;
	localparam int HIST_TAIL_NS = 500;
	localparam int HIST_TAIL_CYC = (HIST_TAIL_NS * CLK_MHZ) / 1000;
	localparam int TAIL_W = 4;
endpackage
`default_nettype wire

// ### verif/scr_assertions.sv
// Purpose: Port checker for the serial command register.
// Assumes: Decouple flags follow the capacitance fields combinationally.
// Notes: Bound to scr_core below the module.
`default_nettype none
module scr_chk
	import scr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cmd_clk_in,
	input wire logic cmd_clk_out,
	input wire logic cmd_strobe,
	input wire logic cmd_clear_n,
	input wire logic [CHAINS-1:0][CAP_W-1:0] stim_cap_select,
	input wire logic [CHAINS-1:0] stim_decouple,
	input wire logic [CHAINS-1:0] chain_power_on,
	input wire logic [CHAINS-1:0] monitor_route,
	input wire logic [PROBE_SEL_W-1:0] probe_select,
	input wire logic probe_enable,
	input wire logic probe_ext_route
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [CHAINS-1:0] dec_exp;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn || !cmd_clear_n);
	always_comb
	begin
		for (int i = 0; i < CHAINS; i++)
		begin
			dec_exp[i] = stim_cap_select[i] == '0;
		end
	end
	clk_copy_a: assert property (cmd_clk_out == cmd_clk_in)
		else $error("clock out differs from clock in");
	apb_ready_a: assert property (psel && penable |-> pready)
		else $error("no ready in access phase");
	unmapped_err_a: assert property
		(psel && penable && paddr > REG_CMD_WORD |-> pslverr)
		else $error("unmapped access without error");
	cap_decouple_a: assert property (stim_decouple == dec_exp)
		else $error("decouple flags disagree with cap select");
	mon_onehot_a: assert property ($onehot0(monitor_route))
		else $error("more than one preamp routed");
	probe_ext_a: assert property (probe_ext_route ==
		$past(probe_enable && probe_select == PROBE_SRC_EXT))
		else $error("external probe route wrong");
	cmd_hold_a: assert property
		((!cmd_strobe)[*6] |-> $stable(chain_power_on))
		else $error("command changed without strobe");
	clear_zero_a: assert property (disable iff (!presetn)
		!cmd_clear_n |-> chain_power_on == '0 && !probe_enable)
		else $error("command not cleared");
endmodule
bind scr_core scr_chk chk (.*);
`default_nettype wire

// ### verif/scr_loader.sv
// Purpose: Controller model that loads the chain serially and strobes.
// Assumes: One chip in the chain; link clock runs only inside a frame.
// Notes: Data is inverted after a frame so stale bits never look valid.
`default_nettype none
module scr_loader (
	output var logic lclk,
	output var logic ldata,
	output var logic lstb
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		lclk = 1'b0;
		ldata = 1'b0;
		lstb = 1'b0;
	end
	// Bit 0 goes first so it ends at the far end of the chain.
	task automatic shift(input logic [845:0] v);
		for (int i = 0; i < 846; i++)
		begin
			ldata = v[i];
			#15 lclk = 1'b1;
			#15 lclk = 1'b0;
		end
		ldata = ~ldata;
	endtask
	// Held well past three pclk periods on each level.
	task automatic strobe;
		#100 lstb = 1'b1;
		#600 lstb = 1'b0;
		#600;
	endtask
endmodule
`default_nettype wire

// ### verif/serial_command_register_bench.sv
// Purpose: Self-checking bench for the serial command register.
// Assumes: Derived outputs settle within six pclk cycles.
// Notes: One chip; the loader model drives the serial link.
`default_nettype none
module serial_command_register_bench;
	import scr_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, er, cmd_clk_in, cmd_data_in, cmd_strobe;
	logic cmd_clear_n = 0, cmd_clk_out, cmd_data_out;
	logic gate_close = 0, stim_gate = 0, probe_enable, probe_ext_route;
	logic [15:0] disc_hg = '0, disc_lg = '0, stim_connect_high;
	logic [15:0] stim_decouple, chain_power_on, monitor_route;
	logic [15:0][3:0] stim_cap_select;
	logic [7:0] probe_select;
	logic [31:0] rundown_in = '0;
	logic [2:0] rundown_group_or;
	logic [845:0] v;
	int bad_count = 0, num_checks = 0, cyc = 0;
	scr_core dut (.*);
	scr_loader ld (.lclk(cmd_clk_in), .ldata(cmd_data_in),
		.lstb(cmd_strobe));
	initial forever #50 pclk = ~pclk;
	task automatic summarize;
		if (bad_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			bad_count++;
			summarize;
		end
	end
	task automatic chk(input string n, input logic [31:0] x, g);
		num_checks++;
		if (g !== x)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic t_clear;
		chk("power", 0, chain_power_on);
		chk("monitor", 0, monitor_route);
		cmd_clear_n <= 1'b1;
	endtask
	task automatic t_load;
		v = '0;
		v[0] = 1'b1;
		v[65] = 1'b1;
		v[PCTL_LSB + PCTL_POWER] = 1'b1;
		v[PCTL_LSB + 5 * PCTL_STRIDE + PCTL_POWER] = 1'b1;
		v[TEST_LSB + 12 * TEST_STRIDE + TEST_ENABLE] = 1'b1;
		v[TEST_LSB + 12 * TEST_STRIDE + TEST_CAP_LSB +: 4] = 4'h5;
		v[MON_EN_BIT] = 1'b1;
		v[MON_SEL_LSB +: 4] = 4'h6;
		v[PROBE_EN_BIT] = 1'b1;
		v[PROBE_SEL_LSB +: 8] = PROBE_SRC_EXT;
		ld.shift(v);
		w(3);
		chk("power unlatched", 0, chain_power_on);
		chk("data out", 1, cmd_data_out);
		ld.strobe;
		w(6);
		chk("power", 32'h21, chain_power_on);
		chk("cap", 5, stim_cap_select[3]);
		chk("decouple", 32'hfff7, stim_decouple);
		chk("monitor", 32'h40, monitor_route);
		chk("probe ext", 1, probe_ext_route);
		chk("probe sel", 32'h01, probe_select);
		chk("probe en", 1, probe_enable);
	endtask
	task automatic t_stim;
		stim_gate <= 1'b1;
		w(6);
		chk("stim", 32'h8, stim_connect_high);
		stim_gate <= 1'b0;
		rundown_in <= 32'h2;
		w(6);
		chk("stim", 0, stim_connect_high);
		chk("gor", 1, rundown_group_or);
		rundown_in <= 32'h1;
		w(6);
		chk("gor", 4, rundown_group_or);
		rundown_in <= '0;
	endtask
	task automatic t_hist;
		apb(1'b1, REG_HIST_SEL, 0);
		disc_hg <= 16'h1;
		w(60);
		apb(1'b0, REG_HIST_DATA, 0);
		chk("history", 32'hffff, rd);
		gate_close <= 1'b1;
		w(20);
		disc_hg <= '0;
		w(60);
		apb(1'b0, REG_HIST_DATA, 0);
		chk("history frozen", 32'hffff, rd);
		apb(1'b0, REG_STATUS, 0);
		chk("status", 32'h10003, rd);
		apb(1'b1, REG_CTRL, 32'h1);
		apb(1'b0, REG_CTRL, 0);
		chk("hold", 32'h1, rd);
		apb(1'b1, REG_CTRL, 32'h0);
		gate_close <= 1'b0;
	endtask
	task automatic t_apb;
		apb(1'b1, REG_WORD_SEL, 3);
		apb(1'b0, REG_CMD_WORD, 0);
		chk("cmd word", v[127:96], rd);
		chk("mapped err", 0, er);
		apb(1'b0, 12'h018, 0);
		chk("unmapped err", 1, er);
		chk("unmapped data", 0, rd);
	endtask
	task automatic t_async;
		@(posedge pclk);
		cmd_clear_n <= 1'b0;
		#20;
		chk("cleared", 0, chain_power_on);
		@(posedge pclk);
		cmd_clear_n <= 1'b1;
	endtask
	initial
	begin
		w(5);
		presetn <= 1'b1;
		t_clear;
		t_load;
		t_stim;
		t_hist;
		t_apb;
		t_async;
		summarize;
	end
endmodule
`default_nettype wire
